/* src/pmd_pkg.sv */
// package for the peripheral module disable register bank
// assumes a 32-bit avalon-mm slave, word addressed by byte address
//
// Contract
// - the encoder interface is held off while bit 10 of module_disable_1 is 1, runs while 0.
// - the first serial port is off while bit 5 of module_disable_1 is 1, on while 0.
// - the second spi is off while bit 4 of module_disable_1 is 1, on while 0.
// - the first spi is off while bit 3 of module_disable_1 is 1, on while 0.
package pmd_pkg;
  localparam int unsigned PMD_ADDR_W = 6;
  localparam int unsigned PMD_REG_W  = 16;
  localparam int unsigned PMD_NREG   = 8;
  localparam int unsigned PMD_IDX_W  = 3;

  localparam logic [PMD_ADDR_W-1:0] PMD_OFF_LOCK = 6'h00;
  localparam logic [PMD_ADDR_W-1:0] PMD_OFF_MD1  = 6'h04;
  localparam logic [PMD_ADDR_W-1:0] PMD_OFF_MD2  = 6'h08;
  localparam logic [PMD_ADDR_W-1:0] PMD_OFF_MD3  = 6'h0c;
  localparam logic [PMD_ADDR_W-1:0] PMD_OFF_MD4  = 6'h10;
  localparam logic [PMD_ADDR_W-1:0] PMD_OFF_MD6  = 6'h14;
  localparam logic [PMD_ADDR_W-1:0] PMD_OFF_MD7  = 6'h18;
  localparam logic [PMD_ADDR_W-1:0] PMD_OFF_MD8  = 6'h1c;

  localparam logic [PMD_IDX_W-1:0] PMD_IDX_LOCK = 3'h0;
  localparam logic [PMD_IDX_W-1:0] PMD_IDX_MD1  = 3'h1;

  // implemented bit masks, index order lock, md1, md2, md3, md4, md6, md7, md8
  localparam logic [PMD_REG_W-1:0] PMD_MASK [PMD_NREG] = '{
    16'h0800, 16'h0efb, 16'h00ff, 16'h0082,
    16'h0008, 16'h3f00, 16'h0108, 16'h183e};

  localparam logic [PMD_REG_W-1:0] PMD_RST_VAL = 16'h0000;

  localparam int unsigned PMD_BIT_LOCK   = 11;
  localparam int unsigned PMD_BIT_ENC    = 10;
  localparam int unsigned PMD_BIT_SER1   = 5;
  localparam int unsigned PMD_BIT_SPI2   = 4;
  localparam int unsigned PMD_BIT_SPI1   = 3;

  typedef logic [PMD_REG_W-1:0] pmd_word_t;

  typedef struct packed {
    pmd_word_t [PMD_NREG-1:0] regs;
    logic                     rvalid;
    logic [31:0]              rdata;
  } pmd_state_t;

  function automatic logic pmd_hit(input logic [PMD_ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a[PMD_ADDR_W-1:2] < PMD_NREG);
  endfunction
endpackage

/* src/pmd_bank.sv */
// peripheral module disable register bank with avalon-mm slave
// assumes master holds the request until waitrequest is low
`timescale 1ns/100ps
`default_nettype none
module pmd_bank
  import pmd_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  clk_en_i,
  input  wire logic [PMD_ADDR_W-1:0] avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [31:0]           avs_writedata_i,
  input  wire logic [3:0]            avs_byteenable_i,
  output logic      [31:0]           avs_readdata_o,
  output logic                       avs_waitrequest_o,
  output logic                       avs_response_err_o,
  output logic                       encoder_interface_off_o,
  output logic                       serial_port1_off_o,
  output logic                       spi_second_off_o,
  output logic                       spi_first_off_o,
  output logic      [PMD_REG_W-1:0]  module_disable_1_o,
  output logic                       module_disable_lock_o
);
  pmd_state_t st_reg;
  pmd_state_t st_next;
  logic [PMD_IDX_W-1:0] idx;
  logic                 hit;
  logic                 locked;
  pmd_word_t            wmask;

  // one byte lane of the write data
  localparam int unsigned LANE_W = 8;

  assign idx    = avs_address_i[PMD_IDX_W+1:2];
  assign hit    = pmd_hit(avs_address_i);
  assign locked = st_reg.regs[PMD_IDX_LOCK][PMD_BIT_LOCK];
  assign wmask  = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    if (avs_write_i && hit) begin
      // lock freezes disable bits; lock itself stays writable to release it
      if (!locked || idx == PMD_IDX_LOCK) begin
        // masked write, unimplemented bits stay zero
        st_next.regs[idx] = (st_reg.regs[idx] & ~wmask)
                          | (avs_writedata_i[PMD_REG_W-1:0] & wmask & PMD_MASK[idx]);
      end
    end
    if (avs_read_i && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = hit ? {16'h0000, st_reg.regs[idx] & PMD_MASK[idx]} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= '0; // all disables clear
    end else if (clk_en_i) begin
      st_reg <= st_next;
    end
  end

  // writes complete at once, reads take one wait cycle
  assign avs_waitrequest_o  = avs_read_i && !st_reg.rvalid;
  assign avs_readdata_o     = st_reg.rdata;
  assign avs_response_err_o = (avs_read_i || avs_write_i) && !hit;

  assign module_disable_1_o      = st_reg.regs[PMD_IDX_MD1];
  assign module_disable_lock_o   = locked;
  assign encoder_interface_off_o = st_reg.regs[PMD_IDX_MD1][PMD_BIT_ENC];
  assign serial_port1_off_o      = st_reg.regs[PMD_IDX_MD1][PMD_BIT_SER1];
  assign spi_second_off_o        = st_reg.regs[PMD_IDX_MD1][PMD_BIT_SPI2];
  assign spi_first_off_o         = st_reg.regs[PMD_IDX_MD1][PMD_BIT_SPI1];

  // outputs follow their register bits
  a_enc_follow: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    encoder_interface_off_o == module_disable_1_o[PMD_BIT_ENC])
    else $error("encoder off not tracking bit");

  a_ser1_follow: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    serial_port1_off_o == module_disable_1_o[PMD_BIT_SER1])
    else $error("serial port off not tracking bit");

  a_spi2_follow: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    spi_second_off_o == module_disable_1_o[PMD_BIT_SPI2])
    else $error("second spi off not tracking bit");

  a_spi1_follow: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    spi_first_off_o == module_disable_1_o[PMD_BIT_SPI1])
    else $error("first spi off not tracking bit");

  a_unimpl_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (module_disable_1_o & ~PMD_MASK[PMD_IDX_MD1]) == 16'h0000)
    else $error("unimplemented bit set");

  // every register of the bank keeps its holes empty
  for (genvar g = 0; g < PMD_NREG; g++) begin : g_unimpl
    a_reg_unimpl: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (st_reg.regs[g] & ~PMD_MASK[g]) == 16'h0000)
      else $error("unimplemented bit set in bank");
  end

  a_md1_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && avs_write_i && avs_address_i == PMD_OFF_MD1 && !locked
     && avs_byteenable_i[1:0] == 2'h3)
    |=> module_disable_1_o == ($past(avs_writedata_i[15:0]) & PMD_MASK[PMD_IDX_MD1]))
    else $error("md1 write not stored");

  // single bit writes land on the named outputs
  a_enc_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && avs_write_i && avs_address_i == PMD_OFF_MD1 && !locked
     && avs_byteenable_i[PMD_BIT_ENC / LANE_W])
    |=> encoder_interface_off_o == $past(avs_writedata_i[PMD_BIT_ENC]))
    else $error("encoder off write lost");

  a_ser1_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && avs_write_i && avs_address_i == PMD_OFF_MD1 && !locked
     && avs_byteenable_i[PMD_BIT_SER1 / LANE_W])
    |=> serial_port1_off_o == $past(avs_writedata_i[PMD_BIT_SER1]))
    else $error("serial port off write lost");

  a_spi2_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && avs_write_i && avs_address_i == PMD_OFF_MD1 && !locked
     && avs_byteenable_i[PMD_BIT_SPI2 / LANE_W])
    |=> spi_second_off_o == $past(avs_writedata_i[PMD_BIT_SPI2]))
    else $error("second spi off write lost");

  a_spi1_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && avs_write_i && avs_address_i == PMD_OFF_MD1 && !locked
     && avs_byteenable_i[PMD_BIT_SPI1 / LANE_W])
    |=> spi_first_off_o == $past(avs_writedata_i[PMD_BIT_SPI1]))
    else $error("first spi off write lost");

  // lock freezes each disable output
  a_lock_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (locked && clk_en_i) |=> $stable(module_disable_1_o))
    else $error("md1 changed while locked");

  a_enc_locked: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    locked |=> $stable(encoder_interface_off_o))
    else $error("encoder off changed while locked");

  a_ser1_locked: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    locked |=> $stable(serial_port1_off_o))
    else $error("serial port off changed while locked");

  a_spi2_locked: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    locked |=> $stable(spi_second_off_o))
    else $error("second spi off changed while locked");

  a_spi1_locked: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    locked |=> $stable(spi_first_off_o))
    else $error("first spi off changed while locked");

  a_lock_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && avs_write_i && avs_address_i == PMD_OFF_LOCK
     && avs_byteenable_i[PMD_BIT_LOCK / LANE_W])
    |=> locked == $past(avs_writedata_i[PMD_BIT_LOCK]))
    else $error("lock write lost");

  // byte lanes left out of a write keep their bits
  a_lane_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (avs_write_i && avs_address_i == PMD_OFF_MD1 && !avs_byteenable_i[0])
    |=> module_disable_1_o[LANE_W-1:0] == $past(module_disable_1_o[LANE_W-1:0]))
    else $error("low lane changed without enable");

  a_lane_high: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (avs_write_i && avs_address_i == PMD_OFF_MD1 && !avs_byteenable_i[1])
    |=> module_disable_1_o[PMD_REG_W-1:LANE_W] == $past(module_disable_1_o[PMD_REG_W-1:LANE_W]))
    else $error("high lane changed without enable");

  // clock enable low freezes everything
  a_ce_freeze: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !clk_en_i |=> $stable(st_reg))
    else $error("state moved with clock enable low");

  // bus handshake
  a_read_wait: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (avs_read_i && !st_reg.rvalid && clk_en_i) |=> !avs_waitrequest_o)
    else $error("read not answered in one cycle");

  a_read_stall: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (avs_read_i && !st_reg.rvalid) |-> avs_waitrequest_o)
    else $error("read answered before data");

  a_write_nowait: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (avs_write_i && !avs_read_i) |-> !avs_waitrequest_o)
    else $error("write stalled");

  a_rvalid_pulse: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_reg.rvalid && clk_en_i) |=> !st_reg.rvalid)
    else $error("read answer held too long");

  a_md1_read: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && avs_read_i && !st_reg.rvalid && avs_address_i == PMD_OFF_MD1)
    |=> avs_readdata_o[PMD_REG_W-1:0] == $past(module_disable_1_o))
    else $error("md1 read data wrong");

  a_unmap_read: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (clk_en_i && avs_read_i && !st_reg.rvalid && !hit) |=> avs_readdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_rd_upper: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    avs_readdata_o[31:PMD_REG_W] == 16'h0000)
    else $error("read data upper half set");

  // reset clears every disable, so all peripherals start on
  a_reset_clear: assert property (@(posedge clk_i)
    !rst_b_i |-> st_reg == '0)
    else $error("state not cleared in reset");

  a_enc_reset: assert property (@(posedge clk_i)
    !rst_b_i |-> !encoder_interface_off_o)
    else $error("encoder off set in reset");

  a_ser1_reset: assert property (@(posedge clk_i)
    !rst_b_i |-> !serial_port1_off_o)
    else $error("serial port off set in reset");

  a_spi2_reset: assert property (@(posedge clk_i)
    !rst_b_i |-> !spi_second_off_o)
    else $error("second spi off set in reset");

  a_spi1_reset: assert property (@(posedge clk_i)
    !rst_b_i |-> !spi_first_off_o)
    else $error("first spi off set in reset");
endmodule
`default_nettype wire

/* verification/pmd_bank_tb.sv */
// bench for pmd_bank: avalon-mm reads and writes, disable outputs
// assumes one clock; reads answer after one wait cycle
`timescale 1ns/100ps
`default_nettype none
module pmd_bank_tb;
  import pmd_pkg::*;
  logic                  clk_i = 1'b0, rst_b_i = 1'b0, rd = 1'b0, wr = 1'b0, ce = 1'b1;
  logic [3:0]            be = 4'hf;
  logic [PMD_ADDR_W-1:0] adr = '0;
  logic [31:0]           wd = '0, rdat, q;
  logic                  wq, err, e, enc, ser, sp2, sp1, lk;
  logic [PMD_REG_W-1:0]  md1;
  int                    num_errors = 0, n_compared = 0;
  pmd_bank dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .clk_en_i(ce), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .avs_response_err_o(err),
    .encoder_interface_off_o(enc), .serial_port1_off_o(ser), .spi_second_off_o(sp2),
    .spi_first_off_o(sp1), .module_disable_1_o(md1), .module_disable_lock_o(lk));
  initial forever #2.5 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // sampled in the active region of the edge, so before the slave's flops move
  task automatic bus(input logic w, input logic [PMD_ADDR_W-1:0] a, input logic [31:0] d);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_i); while (wq);
    q = rdat;
    e = err;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic t_reset;
    chk(32'({enc, ser, sp2, sp1, lk}), 32'h0);
    bus(1'b0, PMD_OFF_MD1, 32'h0);
    chk(q, 32'h0);
  endtask
  task automatic t_bits;
    int b [4] = '{10, 5, 4, 3};
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, PMD_OFF_MD1, 32'h1 << b[i]);
      chk(32'({enc, ser, sp2, sp1}), 32'(4'h8 >> i));
    end
    bus(1'b1, PMD_OFF_MD1, 32'hffff);
    chk(32'({enc, ser, sp2, sp1}), 32'hf);
    bus(1'b0, PMD_OFF_MD1, 32'h0);
    chk(q, 32'(PMD_MASK[1]));
  endtask
  task automatic t_lock;
    bus(1'b1, PMD_OFF_MD1, 32'h0400);
    bus(1'b1, PMD_OFF_LOCK, 32'h0800);
    chk(32'(lk), 32'h1);
    bus(1'b1, PMD_OFF_MD1, 32'h0000);
    chk(32'(md1), 32'h0400);
    bus(1'b0, PMD_OFF_LOCK, 32'h0);
    chk(q, 32'h0800);
    bus(1'b1, PMD_OFF_LOCK, 32'h0);
    bus(1'b1, PMD_OFF_MD1, 32'h0);
    chk(32'({lk, enc}), 32'h0);
  endtask
  task automatic t_bytes;
    bus(1'b1, PMD_OFF_MD1, 32'hffff);
    be <= 4'h1;
    bus(1'b1, PMD_OFF_MD1, 32'h0);
    chk(32'(md1), 32'h0e00);
    chk(32'({enc, ser, sp2, sp1}), 32'h8);
    be <= 4'h2;
    bus(1'b1, PMD_OFF_MD1, 32'h0);
    be <= 4'hf;
    chk(32'(md1), 32'h0);
  endtask
  task automatic t_freeze;
    ce <= 1'b0;
    bus(1'b1, PMD_OFF_MD1, 32'h0038);
    chk(32'({ser, sp2, sp1}), 32'h0);
    ce <= 1'b1;
    bus(1'b1, PMD_OFF_MD1, 32'h0038);
    chk(32'({ser, sp2, sp1}), 32'h7);
  endtask
  task automatic t_rerst;
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(32'({md1, lk, wq}), 32'h0);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    bus(1'b0, PMD_OFF_MD1, 32'h0);
    chk(q, 32'h0);
  endtask
  task automatic t_unmapped;
    bus(1'b0, 6'h20, 32'h0);
    chk({q[30:0], e}, 32'h1);
  endtask
  task automatic end_of_test;
    if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_bits();
    t_lock();
    t_bytes();
    t_freeze();
    t_unmapped();
    t_rerst();
    end_of_test();
  end
endmodule
`default_nettype wire
